/* File: op_model.sv */
// Operator model: interlock, direction switches, motion and pedal.
// Assumes the caller sits on the clock edge grid; levels are always driven.
`timescale 1ns/1ps
module op_model (
	input  wire logic  aclk,
	output logic       interlock_in,
	output logic       dir_fwd_in,
	output logic       dir_rev_in,
	output logic       vehicle_moving,
	output logic [15:0] raw_throttle
);
	initial begin
		interlock_in = 1'b0;
		dir_fwd_in = 1'b0;
		dir_rev_in = 1'b0;
		vehicle_moving = 1'b0;
		raw_throttle = 16'h0000;
	end
	// Switches are real levels, never floating, so no release pattern
	task automatic put(input logic il, f, r, m, input logic [15:0] t);
		@(posedge aclk);
		interlock_in <= il;
		dir_fwd_in <= f;
		dir_rev_in <= r;
		vehicle_moving <= m;
		raw_throttle <= t;
	endtask
endmodule

/* File: pedal_sequence_guard.sv */
// Pedal sequencing guard with AXI4-Lite registers and an interrupt.
// Assumes switch inputs synchronous to aclk; reset synchronous, low.
//
// Contract
// - Lockout type 0..3, type 0 disables checks
// - Any failed check sets fault, flash code 47
// - Type 1: interlock rising with throttle/direction faults
// - Fault clears on throttle return below 25% or directions off, unless a check still fails
// - Type 2: interlock/direction off, stationary, throttle high faults
// - Type 2: direction change while moving is allowed
// - Type 3: interlock/direction off, throttle high faults always
// - Types 2 and 3 ignore switch order
// - Delay 0..1250 masks brief interlock cycling
// - Bypass takes drive command from applied value
// - Four settings condition raw throttle into percent
`timescale 1ns/1ps
module pedal_sequence_guard
	import seq_guard_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = DELAY_UNIT_CYCLES
)
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  ce,
	input  wire logic [AXI_ADDR_W-1:0] awaddr,
	input  wire logic [2:0]            awprot,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [DATA_W-1:0]     wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	input  wire logic [AXI_ADDR_W-1:0] araddr,
	input  wire logic [2:0]            arprot,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [DATA_W-1:0]          rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	input  wire logic                  interlock_in,
	input  wire logic                  dir_fwd_in,
	input  wire logic                  dir_rev_in,
	input  wire logic                  vehicle_moving,
	input  wire logic [15:0]           raw_throttle,
	output logic                       seq_fault,
	output logic [7:0]                 fault_flash_code,
	output logic [15:0]                drive_throttle,
	output logic                       irq
);

	// Register file
	logic [15:0]      seq_delay_reg, seq_delay_next;
	logic [15:0]      bypass_reg, bypass_next;
	logic [1:0]       lockout_reg, lockout_next;
	logic [15:0]      deadband_reg, deadband_next;
	logic [15:0]      map_reg, map_next;
	logic [15:0]      max_reg, max_next;
	logic [15:0]      offset_reg, offset_next;
	logic [15:0]      applied_reg, applied_next;
	logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
	logic [IRQ_W-1:0] irq_en_reg, irq_en_next;

	// Bus channel state
	logic                  aw_held_reg, aw_held_next;
	logic [13:0]           aw_idx_reg, aw_idx_next;
	logic                  w_held_reg, w_held_next;
	logic [DATA_W-1:0]     w_data_reg, w_data_next;
	logic [3:0]            w_strb_reg, w_strb_next;
	logic                  bvalid_reg, bvalid_next;
	logic [1:0]            bresp_reg, bresp_next;
	logic                  rvalid_reg, rvalid_next;
	logic [1:0]            rresp_reg, rresp_next;
	logic [DATA_W-1:0]     rdata_reg, rdata_next;

	// Sequencing state
	ilk_state_t    ilk_state_reg, ilk_state_next;
	fault_state_t  fault_state_reg, fault_state_next;
	logic [31:0]   presc_reg, presc_next;
	logic [15:0]   dcnt_reg, dcnt_next;
	logic [15:0]   drive_reg, drive_next;
	logic [7:0]    flash_reg, flash_next;
	logic          thr_low_reg, dir_on_reg;

	logic [15:0]   pct;
	logic          do_write;
	logic          wr_hit;
	logic [1:0]    wr_resp;
	logic [15:0]   wr_val;
	logic          ilk_eff;
	logic          ilk_rise;
	logic          dir_on;
	logic          thr_high;
	logic          thr_low;
	logic          set_fault;
	logic          clr_fault;
	logic          fault_now;
	logic [15:0]   status_word;
	logic [13:0]   ar_idx;

	throttle_conditioner u_cond (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.ce       (ce),
		.raw      (raw_throttle),
		.deadband (deadband_reg),
		.map_pt   (map_reg),
		.max_pt   (max_reg),
		.offset   (offset_reg),
		.pct      (pct)
	);

	function automatic logic [15:0] merge16(input logic [15:0] old,
	                                        input logic [31:0] d,
	                                        input logic [3:0]  s);
		logic [15:0] r;
		r = old;
		if (s[0]) begin
			r[7:0] = d[7:0];
		end
		if (s[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	// Write channels are taken independently; the write happens once both
	// are held and no response is pending, so one write is in flight.
	assign awready  = !aw_held_reg && !bvalid_reg;
	assign wready   = !w_held_reg && !bvalid_reg;
	assign arready  = !rvalid_reg;
	assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	assign ar_idx   = araddr[15:2];

	always_comb begin
		aw_held_next = aw_held_reg;
		aw_idx_next  = aw_idx_reg;
		w_held_next  = w_held_reg;
		w_data_next  = w_data_reg;
		w_strb_next  = w_strb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		if (awvalid && awready) begin
			aw_held_next = 1'b1;
			aw_idx_next  = awaddr[15:2];
		end
		if (wvalid && wready) begin
			w_held_next = 1'b1;
			w_data_next = wdata;
			w_strb_next = wstrb;
		end
		if (do_write) begin
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = wr_resp;
		end else if (bvalid_reg && bready) begin
			bvalid_next = 1'b0;
		end
	end

	always_comb begin
		case (aw_idx_reg)
			IDX_SEQ_DELAY, IDX_BYPASS, IDX_LOCKOUT, IDX_DEADBAND, IDX_MAP,
			IDX_MAX, IDX_OFFSET, IDX_APPLIED, IDX_IRQ_EN,
			IDX_IRQ_CLR: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
		wr_resp = wr_hit ? RESP_OKAY : RESP_SLVERR;
	end

	// Register updates, including hardware event capture
	always_comb begin
		seq_delay_next = seq_delay_reg;
		bypass_next    = bypass_reg;
		lockout_next   = lockout_reg;
		deadband_next  = deadband_reg;
		map_next       = map_reg;
		max_next       = max_reg;
		offset_next    = offset_reg;
		applied_next   = applied_reg;
		irq_en_next    = irq_en_reg;
		irq_stat_next  = irq_stat_reg;
		wr_val         = 16'h0000;
		if (do_write) begin
			case (aw_idx_reg)
				IDX_SEQ_DELAY: begin
					wr_val = merge16(seq_delay_reg, w_data_reg, w_strb_reg);
					seq_delay_next = (wr_val > DELAY_MAX) ? DELAY_MAX
					                                      : wr_val;
				end
				IDX_BYPASS: begin
					wr_val = merge16(bypass_reg, w_data_reg, w_strb_reg);
					bypass_next = {15'h0000, wr_val[BYPASS_BIT]};
				end
				IDX_LOCKOUT: begin
					wr_val = merge16({14'h0000, lockout_reg}, w_data_reg,
					                 w_strb_reg);
					lockout_next = wr_val[1:0];
				end
				IDX_DEADBAND:
					deadband_next = merge16(deadband_reg, w_data_reg, w_strb_reg);
				IDX_MAP: map_next = merge16(map_reg, w_data_reg, w_strb_reg);
				IDX_MAX: max_next = merge16(max_reg, w_data_reg, w_strb_reg);
				IDX_OFFSET:
					offset_next = merge16(offset_reg, w_data_reg, w_strb_reg);
				IDX_APPLIED:
					applied_next = merge16(applied_reg, w_data_reg, w_strb_reg);
				IDX_IRQ_EN: begin
					if (w_strb_reg[0]) begin
						irq_en_next = w_data_reg[IRQ_W-1:0];
					end
				end
				IDX_IRQ_CLR: begin
					if (w_strb_reg[0]) begin
						irq_stat_next = irq_stat_reg & ~w_data_reg[IRQ_W-1:0];
					end
				end
				default: wr_val = 16'h0000;
			endcase
		end
		// Events set after the clear so a coincident event is kept
		if (fault_now && (fault_state_reg == FS_CLEAR)) begin
			irq_stat_next[IRQ_FAULT_SET] = 1'b1;
		end
		if (!fault_now && (fault_state_reg == FS_FAULT)) begin
			irq_stat_next[IRQ_FAULT_CLR] = 1'b1;
		end
	end

	// Read path
	assign status_word = {12'h000, thr_high, dir_on, ilk_eff,
	                      fault_state_reg == FS_FAULT};

	always_comb begin
		rvalid_next = rvalid_reg;
		rresp_next  = rresp_reg;
		rdata_next  = rdata_reg;
		if (arvalid && arready) begin
			rvalid_next = 1'b1;
			rresp_next  = RESP_OKAY;
			case (ar_idx)
				IDX_SEQ_DELAY: rdata_next = {16'h0000, seq_delay_reg};
				IDX_BYPASS:    rdata_next = {16'h0000, bypass_reg};
				IDX_LOCKOUT:   rdata_next = {30'h00000000, lockout_reg};
				IDX_DEADBAND:  rdata_next = {16'h0000, deadband_reg};
				IDX_MAP:       rdata_next = {16'h0000, map_reg};
				IDX_MAX:       rdata_next = {16'h0000, max_reg};
				IDX_OFFSET:    rdata_next = {16'h0000, offset_reg};
				IDX_APPLIED:   rdata_next = {16'h0000, applied_reg};
				IDX_PROCESSED: rdata_next = {16'h0000, pct};
				IDX_STATUS:    rdata_next = {16'h0000, status_word};
				IDX_IRQ_STAT:  rdata_next = {30'h00000000, irq_stat_reg};
				IDX_IRQ_EN:    rdata_next = {30'h00000000, irq_en_reg};
				IDX_IRQ_CLR:   rdata_next = 32'h00000000;
				default: begin
					rdata_next = 32'h00000000;
					rresp_next = RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && rready) begin
			rvalid_next = 1'b0;
		end
	end

	// Interlock filter: a drop only counts once it outlasts the delay
	assign ilk_eff  = (ilk_state_reg != IL_OFF);
	assign ilk_rise = (ilk_state_reg == IL_OFF) && interlock_in;

	always_comb begin
		ilk_state_next = ilk_state_reg;
		presc_next     = presc_reg;
		dcnt_next      = dcnt_reg;
		case (ilk_state_reg)
			IL_OFF: begin
				if (interlock_in) begin
					ilk_state_next = IL_ON;
				end
			end
			IL_ON: begin
				presc_next = 32'h00000000;
				dcnt_next  = 16'h0000;
				if (!interlock_in) begin
					ilk_state_next = (seq_delay_reg == 16'h0000) ? IL_OFF
					                                             : IL_HOLD;
				end
			end
			IL_HOLD: begin
				if (interlock_in) begin
					ilk_state_next = IL_ON;
				end else if (dcnt_reg >= seq_delay_reg) begin
					ilk_state_next = IL_OFF;
				end else if (presc_reg >= 32'(TICK_CYCLES - 1)) begin
					presc_next = 32'h00000000;
					dcnt_next  = dcnt_reg + 16'h0001;
				end else begin
					presc_next = presc_reg + 32'h00000001;
				end
			end
			default: ilk_state_next = IL_OFF;
		endcase
	end

	// Fault checks
	assign dir_on   = dir_fwd_in || dir_rev_in;
	assign thr_high = pct > THR_25PCT;
	assign thr_low  = pct < THR_25PCT;

	always_comb begin
		case (lockout_reg)
			LOCK_MH:      set_fault = ilk_rise && (thr_high || dir_on);
			// Moving vehicle is exempt, so reversal on the move is fine
			LOCK_GOLF_RV: set_fault = (!ilk_eff || !dir_on) &&
			                          !vehicle_moving && thr_high;
			// Order of interlock and direction is never examined
			LOCK_GOLF_NR: set_fault = (!ilk_eff || !dir_on) &&
			                          thr_high;
			default:      set_fault = 1'b0;
		endcase
		// Clearing needs a return to neutral, not a level already there,
		// or a direction-first fault would vanish one cycle after setting
		clr_fault = (thr_low && !thr_low_reg) ||
		            (!dir_on && dir_on_reg);
		case (fault_state_reg)
			FS_CLEAR: fault_state_next = set_fault ? FS_FAULT : FS_CLEAR;
			FS_FAULT: fault_state_next = (clr_fault && !set_fault) ||
			                             (lockout_reg == LOCK_OFF)
			                             ? FS_CLEAR : FS_FAULT;
			default:  fault_state_next = FS_CLEAR;
		endcase
		fault_now  = (fault_state_next == FS_FAULT);
		flash_next = fault_now ? FLASH_CODE : 8'h00;
		// Fault detection above always uses the conditioned value
		drive_next = bypass_reg[BYPASS_BIT] ? applied_reg : pct;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seq_delay_reg   <= RST_SEQ_DELAY;
			bypass_reg      <= RST_BYPASS;
			lockout_reg     <= RST_LOCKOUT[1:0];
			deadband_reg    <= RST_DEADBAND;
			map_reg         <= RST_MAP;
			max_reg         <= RST_MAX;
			offset_reg      <= RST_OFFSET;
			applied_reg     <= RST_APPLIED;
			irq_stat_reg    <= '0;
			irq_en_reg      <= '0;
			aw_held_reg     <= 1'b0;
			aw_idx_reg      <= 14'h0000;
			w_held_reg      <= 1'b0;
			w_data_reg      <= 32'h00000000;
			w_strb_reg      <= 4'h0;
			bvalid_reg      <= 1'b0;
			bresp_reg       <= RESP_OKAY;
			rvalid_reg      <= 1'b0;
			rresp_reg       <= RESP_OKAY;
			rdata_reg       <= 32'h00000000;
			ilk_state_reg   <= IL_OFF;
			fault_state_reg <= FS_CLEAR;
			presc_reg       <= 32'h00000000;
			dcnt_reg        <= 16'h0000;
			drive_reg       <= 16'h0000;
			flash_reg       <= 8'h00;
			thr_low_reg     <= 1'b1;
			dir_on_reg      <= 1'b0;
		end else if (ce) begin
			seq_delay_reg   <= seq_delay_next;
			bypass_reg      <= bypass_next;
			lockout_reg     <= lockout_next;
			deadband_reg    <= deadband_next;
			map_reg         <= map_next;
			max_reg         <= max_next;
			offset_reg      <= offset_next;
			applied_reg     <= applied_next;
			irq_stat_reg    <= irq_stat_next;
			irq_en_reg      <= irq_en_next;
			aw_held_reg     <= aw_held_next;
			aw_idx_reg      <= aw_idx_next;
			w_held_reg      <= w_held_next;
			w_data_reg      <= w_data_next;
			w_strb_reg      <= w_strb_next;
			bvalid_reg      <= bvalid_next;
			bresp_reg       <= bresp_next;
			rvalid_reg      <= rvalid_next;
			rresp_reg       <= rresp_next;
			rdata_reg       <= rdata_next;
			ilk_state_reg   <= ilk_state_next;
			fault_state_reg <= fault_state_next;
			presc_reg       <= presc_next;
			dcnt_reg        <= dcnt_next;
			drive_reg       <= drive_next;
			flash_reg       <= flash_next;
			thr_low_reg     <= thr_low;
			dir_on_reg      <= dir_on;
		end
	end

	// Ready outputs are combinational; ce low also freezes the bus
	assign bvalid           = bvalid_reg;
	assign bresp            = bresp_reg;
	assign rvalid           = rvalid_reg;
	assign rresp            = rresp_reg;
	assign rdata            = rdata_reg;
	assign seq_fault        = (fault_state_reg == FS_FAULT);
	assign fault_flash_code = flash_reg;
	assign drive_throttle   = drive_reg;
	assign irq              = |(irq_stat_reg & irq_en_reg);

endmodule

/* File: seq_guard_asserts.sv */
// Checker for the pedal sequencing guard, bound to its top module.
// Assumes one clock domain, synchronous active-low reset, ce kept high.
`timescale 1ns/1ps
module seq_guard_asserts
	import seq_guard_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = 4
)
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [1:0]  bresp,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [1:0]  rresp,
	input wire logic [31:0] rdata,
	input wire logic        interlock_in,
	input wire logic        dir_fwd_in,
	input wire logic        dir_rev_in,
	input wire logic [15:0] raw_throttle,
	input wire logic        seq_fault,
	input wire logic [7:0]  fault_flash_code,
	input wire logic        irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_flash_on;
		seq_fault |-> fault_flash_code == FLASH_CODE;
	endproperty
	a_flash_on: assert property (p_flash_on)
		else $error("flash code missing while faulted");
	property p_flash_off;
		!seq_fault |-> fault_flash_code == 8'h00;
	endproperty
	a_flash_off: assert property (p_flash_off)
		else $error("flash code shown without fault");
	// Zero throttle with directions off leaves nothing to hold a fault
	property p_clear;
		(raw_throttle == 16'h0000 && !dir_fwd_in && !dir_rev_in &&
		 $stable(interlock_in))[*4] |=> !seq_fault;
	endproperty
	a_clear: assert property (p_clear)
		else $error("fault held with throttle released");
	property p_cause;
		$rose(seq_fault) |-> $past(raw_throttle, 2) != 16'h0000
			|| $past(dir_fwd_in | dir_rev_in);
	endproperty
	a_cause: assert property (p_cause)
		else $error("fault rose with no throttle or direction");
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped early");
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read response dropped early");
	property p_b_time;
		awvalid && awready && wvalid && wready |-> ##[1:3] bvalid;
	endproperty
	a_b_time: assert property (p_b_time)
		else $error("write response late");
	property p_r_time;
		arvalid && arready |=> rvalid;
	endproperty
	a_r_time: assert property (p_r_time)
		else $error("read response late");
	property p_busy;
		bvalid |-> !awready && !wready;
	endproperty
	a_busy: assert property (p_busy)
		else $error("write channels open during response");
	c_fault: cover property ($rose(seq_fault));
	c_irq: cover property ($rose(irq));
	c_slverr: cover property (rvalid && rresp == RESP_SLVERR);
endmodule
bind pedal_sequence_guard seq_guard_asserts #(.TICK_CYCLES(TICK_CYCLES))
	i_seq_guard_asserts (.aclk, .aresetn, .awvalid, .awready, .wvalid,
	.wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid,
	.rready, .rresp, .rdata, .interlock_in, .dir_fwd_in, .dir_rev_in,
	.raw_throttle, .seq_fault, .fault_flash_code, .irq);

/* File: seq_guard_pkg.sv */
// Constants, register map and state types for the pedal sequencing guard.
// Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
package seq_guard_pkg;

	localparam int AXI_ADDR_W = 16;
	localparam int DATA_W     = 32;
	localparam int REG_W      = 16;

	// Register indices; byte address is four times the index
	localparam logic [13:0] IDX_SEQ_DELAY = 14'h3009;
	localparam logic [13:0] IDX_BYPASS    = 14'h3099;
	localparam logic [13:0] IDX_LOCKOUT   = 14'h30cf;
	localparam logic [13:0] IDX_DEADBAND  = 14'h3100;
	localparam logic [13:0] IDX_MAP       = 14'h3101;
	localparam logic [13:0] IDX_MAX       = 14'h3102;
	localparam logic [13:0] IDX_OFFSET    = 14'h3103;
	localparam logic [13:0] IDX_APPLIED   = 14'h3104;
	localparam logic [13:0] IDX_PROCESSED = 14'h3105;
	localparam logic [13:0] IDX_STATUS    = 14'h3106;
	localparam logic [13:0] IDX_IRQ_STAT  = 14'h3107;
	localparam logic [13:0] IDX_IRQ_EN    = 14'h3108;
	localparam logic [13:0] IDX_IRQ_CLR   = 14'h3109;

	// Values after reset
	localparam logic [15:0] RST_SEQ_DELAY = 16'h0000;
	localparam logic [15:0] RST_BYPASS    = 16'h0000;
	localparam logic [15:0] RST_LOCKOUT   = 16'h0000;
	localparam logic [15:0] RST_DEADBAND  = 16'h0000;
	localparam logic [15:0] RST_MAP       = 16'h4000;
	localparam logic [15:0] RST_MAX       = 16'h7fff;
	localparam logic [15:0] RST_OFFSET    = 16'h0000;
	localparam logic [15:0] RST_APPLIED   = 16'h0000;

	// Throttle scale: 0x7fff is 100 %
	localparam logic [15:0] THR_FULL   = 16'h7fff;
	localparam logic [15:0] THR_HALF   = 16'h4000;
	localparam logic [15:0] THR_25PCT  = 16'h2000;
	localparam logic [15:0] DELAY_MAX  = 16'h04e2;
	localparam logic [7:0]  FLASH_CODE = 8'h2f;

	// One sequencing-delay count is 4 ms (5.0 s over 1250 counts)
	localparam int DELAY_UNIT_US     = 4000;
	localparam int CLK_PERIOD_NS     = 25;
	localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_US * 1000 / CLK_PERIOD_NS;

	// Field positions
	localparam int BYPASS_BIT     = 0;
	localparam int STAT_FAULT     = 0;
	localparam int STAT_INTERLOCK = 1;
	localparam int STAT_DIR_ON    = 2;
	localparam int STAT_THR_HIGH  = 3;
	localparam int IRQ_W          = 2;
	localparam int IRQ_FAULT_SET  = 0;
	localparam int IRQ_FAULT_CLR  = 1;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		LOCK_OFF     = 2'h0,
		LOCK_MH      = 2'h1,
		LOCK_GOLF_RV = 2'h2,
		LOCK_GOLF_NR = 2'h3
	} lockout_type_t;

	typedef enum logic [1:0] {
		FS_CLEAR = 2'h0,
		FS_FAULT = 2'h1
	} fault_state_t;

	typedef enum logic [1:0] {
		IL_OFF  = 2'h0,
		IL_ON   = 2'h1,
		IL_HOLD = 2'h3
	} ilk_state_t;

endpackage

/* File: test_pedal_sequence_guard.sv */
// Self-checking bench for the pedal sequencing guard over AXI4-Lite.
// Assumes a short delay tick so the sequencing delay fits a short run.
`timescale 1ns/1ps
module test_pedal_sequence_guard;
	import seq_guard_pkg::*;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic        interlock_in, dir_fwd_in, dir_rev_in, vehicle_moving;
	logic        seq_fault;
	logic [15:0] awaddr, araddr, raw_throttle, drive_throttle;
	logic [31:0] wdata, rdata, d;
	logic [1:0]  bresp, rresp, r;
	logic [7:0]  fault_flash_code;
	int          err_total = 0;
	int          num_checks = 0;
	pedal_sequence_guard #(.TICK_CYCLES(4)) i_pedal_sequence_guard (
		.aclk, .aresetn, .ce(1'b1), .awaddr, .awprot(3'h0), .awvalid,
		.awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .interlock_in, .dir_fwd_in, .dir_rev_in,
		.vehicle_moving, .raw_throttle, .seq_fault, .fault_flash_code,
		.drive_throttle, .irq);
	op_model i_op_model (.aclk, .interlock_in, .dir_fwd_in, .dir_rev_in,
		.vehicle_moving, .raw_throttle);
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	task final_report;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task chk(input logic [31:0] g, e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task tmo;
		err_total++;
		$display("[FAIL] %0t bus wait ran out", $time);
		final_report;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Answers are taken at the rising edge; inputs move only after edges
	task automatic axw(input logic [13:0] ix, input logic [31:0] v);
		logic a, w, b;
		int n;
		@(posedge aclk);
		awaddr <= {ix, 2'h0};
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b = 1'b0;
		n = 0;
		while (!b && n < 50) begin
			@(posedge aclk);
			a = awvalid & awready;
			w = wvalid & wready;
			b = bvalid;
			r = bresp;
			if (a) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			n++;
		end
		bready <= 1'b0;
		if (!b) tmo();
	endtask
	task automatic axr(input logic [13:0] ix);
		logic a, v;
		int n;
		@(posedge aclk);
		araddr <= {ix, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		v = 1'b0;
		n = 0;
		while (!v && n < 50) begin
			@(posedge aclk);
			a = arvalid & arready;
			v = rvalid;
			d = rdata;
			r = rresp;
			if (a) arvalid <= 1'b0;
			n++;
		end
		rready <= 1'b0;
		if (!v) tmo();
	endtask
	task sf(input logic e);
		cyc(4);
		chk(seq_fault, e);
	endtask
	task s_regs;
		axr(IDX_LOCKOUT); chk(d, 32'h0);
		axr(IDX_MAP); chk(d, RST_MAP);
		axr(14'h0001); chk(r, RESP_SLVERR);
		axw(14'h0001, 32'h0); chk(r, RESP_SLVERR);
		axw(IDX_SEQ_DELAY, 32'h7d0); axr(IDX_SEQ_DELAY); chk(d, DELAY_MAX);
		axw(IDX_SEQ_DELAY, 32'h0);
		axw(IDX_IRQ_EN, 32'h3);
	endtask
	task s_type0;
		i_op_model.put(0, 1, 0, 0, THR_FULL);
		cyc(3);
		i_op_model.put(1, 1, 0, 0, THR_FULL);
		sf(0);
		i_op_model.put(0, 0, 0, 0, 0);
	endtask
	task s_type1;
		axw(IDX_LOCKOUT, 1);
		i_op_model.put(0, 1, 0, 0, 0);
		cyc(3);
		i_op_model.put(1, 1, 0, 0, 0);
		sf(1);
		chk(fault_flash_code, FLASH_CODE);
		chk(irq, 1);
		i_op_model.put(1, 0, 0, 0, 0);
		sf(0);
		axr(IDX_IRQ_STAT); chk(d, 32'h3);
		axw(IDX_IRQ_CLR, 32'h3); cyc(2); chk(irq, 0);
		i_op_model.put(0, 0, 0, 0, THR_FULL);
		cyc(3);
		i_op_model.put(1, 0, 0, 0, THR_FULL);
		sf(1);
		i_op_model.put(1, 0, 0, 0, 0);
		sf(0);
	endtask
	// Delay 5 with a 4-cycle tick masks drops shorter than 22 cycles
	task s_delay;
		axw(IDX_SEQ_DELAY, 32'h5);
		i_op_model.put(1, 1, 0, 0, 0);
		cyc(3);
		i_op_model.put(0, 1, 0, 0, 0);
		cyc(5);
		i_op_model.put(1, 1, 0, 0, 0);
		sf(0);
		i_op_model.put(0, 1, 0, 0, 0);
		cyc(60);
		i_op_model.put(1, 1, 0, 0, 0);
		sf(1);
		i_op_model.put(1, 0, 0, 0, 0);
		sf(0);
		axw(IDX_SEQ_DELAY, 32'h0);
	endtask
	task s_type2;
		axw(IDX_LOCKOUT, 2);
		i_op_model.put(0, 0, 0, 0, THR_FULL);
		sf(1);
		i_op_model.put(0, 0, 0, 0, 0);
		sf(0);
		i_op_model.put(1, 1, 0, 1, THR_FULL);
		sf(0);
		i_op_model.put(1, 0, 1, 1, THR_FULL);
		sf(0);
		i_op_model.put(1, 0, 0, 1, THR_FULL);
		sf(0);
		i_op_model.put(1, 1, 0, 1, 0);
		cyc(3);
		i_op_model.put(0, 1, 0, 0, 0);
		cyc(3);
		i_op_model.put(1, 1, 0, 0, 0);
		sf(0);
	endtask
	task s_type3;
		axw(IDX_LOCKOUT, 3);
		i_op_model.put(1, 1, 0, 1, THR_FULL);
		sf(0);
		i_op_model.put(1, 0, 0, 1, THR_FULL);
		sf(1);
		i_op_model.put(1, 0, 1, 1, THR_FULL);
		sf(1);
		i_op_model.put(1, 0, 1, 1, 0);
		sf(0);
	endtask
	task s_bypass;
		axw(IDX_APPLIED, 32'h1234);
		axw(IDX_BYPASS, 32'h1);
		cyc(3);
		chk(drive_throttle, 16'h1234);
		i_op_model.put(0, 0, 0, 0, THR_FULL);
		sf(1);
		chk(drive_throttle, 16'h1234);
		i_op_model.put(0, 0, 0, 0, 0);
		sf(0);
		axw(IDX_BYPASS, 32'h0);
		cyc(3);
		chk(drive_throttle, 16'h0);
		axw(IDX_LOCKOUT, 0);
	endtask
	initial begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 16'h0000;
		araddr = 16'h0000;
		wdata = 32'h0;
		cyc(5);
		aresetn <= 1'b1;
		s_regs;
		s_type0;
		s_type1;
		s_delay;
		s_type2;
		s_type3;
		s_bypass;
		final_report;
	end
endmodule

/* File: throttle_conditioner.sv */
// Conditions the raw throttle reading into one percentage command.
// Assumes raw and settings on the 0..0x7fff scale, synchronous to aclk.
`timescale 1ns/1ps
module throttle_conditioner
	import seq_guard_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [15:0] raw,
	input  wire logic [15:0] deadband,
	input  wire logic [15:0] map_pt,
	input  wire logic [15:0] max_pt,
	input  wire logic [15:0] offset,
	output logic      [15:0] pct
);

	logic [15:0] pct_reg;
	logic [15:0] pct_next;
	logic [31:0] pos;
	logic [31:0] span;
	logic [31:0] x;
	logic [31:0] y;
	logic [31:0] z;

	// Variable divide kept combinational; result is registered
	always_comb begin
		pos      = 32'(raw) - 32'(deadband);
		span     = (max_pt > deadband) ? 32'(max_pt) - 32'(deadband)
		                               : 32'h1;
		x        = (raw >= max_pt) ? 32'(THR_FULL)
		                           : (pos * 32'(THR_FULL)) / span;
		if (x < 32'(THR_HALF)) begin
			y = (x * 32'(map_pt)) >> 14;
		end else begin
			y = 32'(map_pt) + (((x - 32'(THR_HALF)) *
			    (32'(THR_FULL) - 32'(map_pt))) >> 14);
		end
		if (y > 32'(THR_FULL)) begin
			y = 32'(THR_FULL);
		end
		z        = 32'(offset) + ((y * (32'(THR_FULL) - 32'(offset))) >> 15);
		pct_next = (raw <= deadband) ? 16'h0000 : z[15:0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pct_reg <= 16'h0000;
		end else if (ce) begin
			pct_reg <= pct_next;
		end
	end

	assign pct = pct_reg;

endmodule
